// ### cdt_regs.sv
// Input-regulation status and safety-timer/thermistor control registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Status bit 7 reads 1 while minimum system voltage mode is active.
// (R2) Status bit 6 reads 1 while input voltage regulation is active.
// (R3) Bits 5:3 USB, 2:0 main input thresholds, 80 mV steps, reset zero.
// (R4) Timer bits 6:5 pick 27 min, 6 h, 9 h or timers off; reset 00.
// (R5) Slowdown bit 7 halves timer speed while a slowing condition holds.
// (R6) Slowing: current limit, voltage or thermal loop, half, short, cool.
// (R7) Bit 3 enables thermistor monitoring; reset value one.
// (R8) Read-only bits 2:1 report the thermistor fault code.
// (R9) Bit 0 selects half the programmed fast-charge current; reset zero.
// (R10) Host writes leave read-only status and fault bits live and unchanged.
module cdt_regs
    import cdt_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_hit_o,
    input  wire logic       min_system_voltage_i,
    input  wire logic       input_regulation_i,
    input  wire logic       input_current_limit_i,
    input  wire logic       thermal_regulation_i,
    input  wire logic       battery_short_condition_i,
    input  wire logic [1:0] thermistor_fault_i,
    output logic      [2:0] usb_input_threshold_o,
    output logic      [2:0] main_input_threshold_o,
    output logic      [1:0] safety_limit_sel_o,
    output logic            safety_timers_off_o,
    output logic            timer_half_speed_o,
    output logic            thermistor_monitor_enable_o,
    output logic            half_current_select_o
);
    // ----------------------------------------------------------------
    // Condition inputs cross in from the analog side.
    // ----------------------------------------------------------------
    logic [6:0] cond_sync;
    cdt_sync #(.W(7)) u_sync (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .async_i ({min_system_voltage_i, input_regulation_i,
                   input_current_limit_i, thermal_regulation_i,
                   battery_short_condition_i, thermistor_fault_i}),
        .level_o (cond_sync)
    );
    wire       minsys_s = cond_sync[6];
    wire       dpm_s    = cond_sync[5];
    wire       ilim_s   = cond_sync[4];
    wire       therm_s  = cond_sync[3];
    wire       short_s  = cond_sync[2];
    wire [1:0] fault_s  = cond_sync[1:0];

    // ----------------------------------------------------------------
    // Register state.
    // ----------------------------------------------------------------
    logic [2:0] usb_thr_q,  usb_thr_d;
    logic [2:0] main_thr_q, main_thr_d;
    logic       slow_q,     slow_d;
    logic [1:0] lim_q,      lim_d;
    logic       spare_q,    spare_d;
    logic       thermistor_monitor_enable_q,    thermistor_monitor_enable_d;
    logic       half_q,     half_d;
    logic [7:0] rdata_q,    rdata_d;
    logic       hit_q,      hit_d;
    logic       halfspd_q,  halfspd_d;
    logic       off_q,      off_d;

    wire sel_status = (reg_addr_i == CDT_REG_STATUS_OFS);
    wire sel_timer  = (reg_addr_i == CDT_REG_TIMER_OFS);
    wire wr_status  = reg_wr_i && sel_status;
    wire wr_timer   = reg_wr_i && sel_timer;

    // Only the writable fields take data; status bits have no write path.
    assign usb_thr_d  = wr_status ? reg_wdata_i[CDT_USB_HI:CDT_USB_LO]
                                  : usb_thr_q; // [R3] [R10]
    assign main_thr_d = wr_status ? reg_wdata_i[CDT_MAIN_HI:CDT_MAIN_LO]
                                  : main_thr_q; // [R3]
    assign slow_d  = wr_timer ? reg_wdata_i[CDT_SLOW_BIT] : slow_q; // [R5]
    assign lim_d   = wr_timer ? reg_wdata_i[CDT_LIM_HI:CDT_LIM_LO]
                              : lim_q; // [R4]
    assign spare_d = wr_timer ? reg_wdata_i[CDT_SPARE_BIT] : spare_q;
    assign thermistor_monitor_enable_d = wr_timer ? reg_wdata_i[CDT_THERMISTOR_MONITOR_ENABLE_BIT] : thermistor_monitor_enable_q; // [R7]
    assign half_d  = wr_timer ? reg_wdata_i[CDT_HALF_BIT] : half_q; // [R9]

    // Cool zone only counts while the monitor is enabled.
    wire ts_cool = thermistor_monitor_enable_q && (fault_s == CDT_TS_COOL);
    wire slowing = ilim_s || dpm_s || therm_s || half_q
                   || short_s || ts_cool; // [R6]
    assign halfspd_d = slow_q && slowing; // [R5]

    // Registered so that the disable flag leaves a flip-flop like the rest.
    assign off_d = (lim_d == CDT_LIM_OFF); // [R4]

    // Status fields read live from the synchronised conditions.
    wire [7:0] status_word = {minsys_s, dpm_s, usb_thr_q,
                              main_thr_q}; // [R1] [R2] [R10]
    wire [7:0] timer_word  = {slow_q, lim_q, spare_q, thermistor_monitor_enable_q,
                              fault_s, half_q}; // [R8] [R10]
    assign rdata_d = !reg_rd_i  ? rdata_q :
                     sel_status ? status_word :
                     sel_timer  ? timer_word  : 8'h00;
    assign hit_d   = (reg_rd_i || reg_wr_i) && (sel_status || sel_timer);

    // ----------------------------------------------------------------
    // Flip-flops.
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            usb_thr_q  <= CDT_THR_RESET;
            main_thr_q <= CDT_THR_RESET;
            slow_q     <= CDT_SLOW_RESET;
            lim_q      <= CDT_LIM_RESET;
            spare_q    <= CDT_SPARE_RESET;
            thermistor_monitor_enable_q    <= CDT_THERMISTOR_MONITOR_ENABLE_RESET;
            half_q     <= CDT_HALF_RESET;
            rdata_q    <= 8'h00;
            hit_q      <= 1'b0;
            halfspd_q  <= 1'b0;
            off_q      <= (CDT_LIM_RESET == CDT_LIM_OFF);
        end else begin
            usb_thr_q  <= usb_thr_d;
            main_thr_q <= main_thr_d;
            slow_q     <= slow_d;
            lim_q      <= lim_d;
            spare_q    <= spare_d;
            thermistor_monitor_enable_q    <= thermistor_monitor_enable_d;
            half_q     <= half_d;
            rdata_q    <= rdata_d;
            hit_q      <= hit_d;
            halfspd_q  <= halfspd_d;
            off_q      <= off_d;
        end
    end

    assign reg_rdata_o                 = rdata_q;
    assign reg_hit_o                   = hit_q;
    assign usb_input_threshold_o       = usb_thr_q;
    assign main_input_threshold_o      = main_thr_q;
    assign safety_limit_sel_o          = lim_q;
    assign safety_timers_off_o         = off_q; // [R4]
    assign timer_half_speed_o          = halfspd_q;
    assign thermistor_monitor_enable_o = thermistor_monitor_enable_q;
    assign half_current_select_o       = half_q;

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // Every field lands one edge after its strobe, hence the next-cycle checks.
    thermistor_monitor_enable_write_a: assert property ( // [R7]
        wr_timer |=> thermistor_monitor_enable_o
                     == $past(reg_wdata_i[CDT_THERMISTOR_MONITOR_ENABLE_BIT]))
        else $error("thermistor enable did not take written value");

    half_write_a: assert property ( // [R9]
        wr_timer |=> half_current_select_o
                     == $past(reg_wdata_i[CDT_HALF_BIT]))
        else $error("half current bit did not take written value");

    limit_write_a: assert property ( // [R4]
        wr_timer |=> safety_limit_sel_o
                     == $past(reg_wdata_i[CDT_LIM_HI:CDT_LIM_LO]))
        else $error("timer limit did not take written value");

    timer_off_a: assert property ( // [R4]
        safety_timers_off_o == (safety_limit_sel_o == CDT_LIM_OFF))
        else $error("timer disable does not follow code");

    thr_write_a: assert property ( // [R3]
        wr_status |=> usb_input_threshold_o
                      == $past(reg_wdata_i[CDT_USB_HI:CDT_USB_LO])
                      && main_input_threshold_o
                      == $past(reg_wdata_i[CDT_MAIN_HI:CDT_MAIN_LO]))
        else $error("threshold did not take written value");

    thr_hold_a: assert property ( // [R3]
        !wr_status |=> $stable(usb_input_threshold_o)
                       && $stable(main_input_threshold_o))
        else $error("threshold changed without a write");

    no_slow_a: assert property ( // [R5]
        !slow_q |=> !timer_half_speed_o)
        else $error("timer slowed while slowdown disabled");

    idle_speed_a: assert property ( // [R5]
        !slowing |=> !timer_half_speed_o)
        else $error("timer slowed with no slowing condition");

    half_slow_a: assert property ( // [R6]
        slow_q && half_q |=> timer_half_speed_o)
        else $error("half current mode did not slow timer");

    cond_slow_a: assert property ( // [R6]
        slow_q && (ilim_s || dpm_s || therm_s || short_s)
        |=> timer_half_speed_o)
        else $error("slowing condition did not slow timer");

    cool_slow_a: assert property ( // [R6]
        slow_q && ts_cool |=> timer_half_speed_o)
        else $error("cool zone did not slow timer");

    status_read_a: assert property ( // [R1] [R2] [R10]
        reg_rd_i && sel_status
        |=> reg_rdata_o[CDT_MINSYS_BIT] == $past(minsys_s)
            && reg_rdata_o[CDT_DPM_BIT] == $past(dpm_s))
        else $error("status bits not read live");

    fault_read_a: assert property ( // [R8]
        reg_rd_i && sel_timer
        |=> reg_rdata_o[CDT_FAULT_HI:CDT_FAULT_LO] == $past(fault_s))
        else $error("fault code not read live");

    write_timer_c: cover property (wr_timer ##1 reg_rd_i && sel_timer);
    slow_on_c:     cover property (timer_half_speed_o);
    status_rd_c:   cover property (reg_rd_i && sel_status && minsys_s);
    cool_slow_c:   cover property (slow_q && ts_cool);
    ts_off_c:      cover property (!thermistor_monitor_enable_q && fault_s == CDT_TS_COOL);
endmodule
`default_nettype wire

// ### cdt_pkg.sv
// Package with register offsets, field positions, reset values and timer codes.
`default_nettype none
package cdt_pkg;
    localparam logic [7:0] CDT_REG_STATUS_OFS = 8'h06;
    localparam logic [7:0] CDT_REG_TIMER_OFS  = 8'h07;
    localparam int CDT_MINSYS_BIT   = 7;
    localparam int CDT_DPM_BIT      = 6;
    localparam int CDT_USB_HI       = 5;
    localparam int CDT_USB_LO       = 3;
    localparam int CDT_MAIN_HI      = 2;
    localparam int CDT_MAIN_LO      = 0;
    localparam int CDT_SLOW_BIT     = 7;
    localparam int CDT_LIM_HI       = 6;
    localparam int CDT_LIM_LO       = 5;
    localparam int CDT_SPARE_BIT    = 4;
    localparam int CDT_THERMISTOR_MONITOR_ENABLE_BIT    = 3;
    localparam int CDT_FAULT_HI     = 2;
    localparam int CDT_FAULT_LO     = 1;
    localparam int CDT_HALF_BIT     = 0;
    localparam logic [2:0] CDT_THR_RESET   = 3'h0;
    localparam logic [1:0] CDT_LIM_RESET   = 2'h0;
    localparam logic       CDT_SLOW_RESET  = 1'b0;
    localparam logic       CDT_THERMISTOR_MONITOR_ENABLE_RESET = 1'b1;
    localparam logic       CDT_HALF_RESET  = 1'b0;
    localparam logic       CDT_SPARE_RESET = 1'b1;
    // Timer limit codes.
    localparam logic [1:0] CDT_LIM_27MIN = 2'h0;
    localparam logic [1:0] CDT_LIM_6H    = 2'h1;
    localparam logic [1:0] CDT_LIM_9H    = 2'h2;
    localparam logic [1:0] CDT_LIM_OFF   = 2'h3;
    // Thermistor fault codes.
    localparam logic [1:0] CDT_TS_NONE    = 2'h0;
    localparam logic [1:0] CDT_TS_SUSPEND = 2'h1;
    localparam logic [1:0] CDT_TS_COOL    = 2'h2;
    localparam logic [1:0] CDT_TS_WARM    = 2'h3;
    localparam int CDT_SYNC_STAGES = 3;
endpackage
`default_nettype wire

// ### cdt_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module cdt_sync
    import cdt_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;

    // A change counts only once the second and third stages agree.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign level_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : level_q[g];
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else begin
            s1_q    <= async_i;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;
endmodule
`default_nettype wire

// ### cdt_host.sv
// Host model that drives reads and writes on the register strobe bus.
`timescale 1ns/1ps
`default_nettype none
module cdt_host (
    input  wire logic       clock_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_hit_i,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o
);
    // -------------------------------------------------------------
    // Bus access
    // -------------------------------------------------------------
    // Released lines carry inverted values so stale data never matches.
    initial begin
        reg_addr_o = 8'hff;
        reg_wdata_o = 8'hff;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic h);
        @(posedge clock_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = w;
        reg_rd_o = !w;
        @(posedge clock_i);
        #1;
        q = reg_rdata_i;
        h = reg_hit_i;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

// ### cdt_regs_test.sv
// Self-checking testbench for the regulation and timer register pair.
`timescale 1ns/1ps
`default_nettype none
module cdt_regs_test import cdt_pkg::*; ;
    logic       clock_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic [7:0] addr, wdata, rdata, q;
    logic       wr, rd, hit, h;
    logic       msys = 1'b0, inreg = 1'b0, ilim = 1'b0, therm = 1'b0;
    logic       bshort = 1'b0;
    logic [1:0] fault = 2'h0;
    logic [2:0] usb, mthr;
    logic [1:0] lim;
    logic       toff, hspd, tsen, half;
    int         mismatches = 0, cmp_count = 0, cycles = 0;
    always #12.5 clock_i = ~clock_i;
    // Ceiling sits well above the few hundred cycles the tests need.
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    cdt_regs DUT (.clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_hit_o(hit), .min_system_voltage_i(msys),
        .input_regulation_i(inreg),
        .input_current_limit_i(ilim), .thermal_regulation_i(therm),
        .battery_short_condition_i(bshort), .thermistor_fault_i(fault),
        .usb_input_threshold_o(usb), .main_input_threshold_o(mthr),
        .safety_limit_sel_o(lim), .safety_timers_off_o(toff),
        .timer_half_speed_o(hspd), .thermistor_monitor_enable_o(tsen),
        .half_current_select_o(half));
    cdt_host HOST (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_hit_i(hit),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                       input logic eh);
        HOST.xfer(1'b0, a, 8'h00, q, h);
        chk("rdata", e, q);
        chk("hit", {7'h0, eh}, {7'h0, h});
    endtask
    task automatic wrc(input logic [7:0] a, input logic [7:0] d);
        HOST.xfer(1'b1, a, d, q, h);
        chk("hit", 8'h01, {7'h0, h});
    endtask
    // Condition inputs pass a synchroniser, so give them time to land.
    task automatic settle();
        repeat (6) @(posedge clock_i);
        #1;
    endtask
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_reset();
        rdc(8'h06, 8'h00, 1'b1);
        rdc(8'h07, 8'h18, 1'b1);
        chk("thermistor_monitor_enable", 8'h01, {7'h0, tsen});
        chk("off", 8'h00, {7'h0, toff});
        $display("test reset done");
    endtask
    task automatic t_thr();
        wrc(8'h06, 8'hea);
        rdc(8'h06, 8'h2a, 1'b1);
        chk("usb", 8'h05, {5'h0, usb});
        chk("main", 8'h02, {5'h0, mthr});
        $display("test thresholds done");
    endtask
    task automatic t_limit();
        for (int i = 0; i < 4; i++) begin
            wrc(8'h07, {1'b0, i[1:0], 5'h18});
            chk("lim", {6'h0, i[1:0]}, {6'h0, lim});
            chk("off", {7'h0, i[1:0] == CDT_LIM_OFF}, {7'h0, toff});
            rdc(8'h07, {1'b0, i[1:0], 5'h18}, 1'b1);
        end
        $display("test limits done");
    endtask
    task automatic t_status();
        msys = 1'b1;
        settle();
        rdc(8'h06, 8'haa, 1'b1);
        msys = 1'b0;
        inreg = 1'b1;
        settle();
        wrc(8'h06, 8'h80);
        rdc(8'h06, 8'h40, 1'b1);
        inreg = 1'b0;
        for (int f = 0; f < 4; f++) begin
            fault = f[1:0];
            settle();
            wrc(8'h07, 8'h1e);
            rdc(8'h07, {5'h03, f[1:0], 1'b0}, 1'b1);
        end
        fault = CDT_TS_NONE;
        $display("test status done");
    endtask
    task automatic t_slow();
        for (int j = 0; j < 6; j++) begin
            ilim = (j == 0);
            inreg = (j == 1);
            therm = (j == 2);
            bshort = (j == 3);
            fault = (j == 4) ? CDT_TS_COOL : CDT_TS_NONE;
            wrc(8'h07, {7'h4c, j == 5});
            chk("half", {7'h0, j == 5}, {7'h0, half});
            settle();
            chk("hspd on", 8'h01, {7'h0, hspd});
            ilim = 1'b0;
            inreg = 1'b0;
            therm = 1'b0;
            bshort = 1'b0;
            fault = CDT_TS_NONE;
            wrc(8'h07, 8'h98);
            settle();
            chk("hspd idle", 8'h00, {7'h0, hspd});
        end
        wrc(8'h07, 8'h80);
        chk("thermistor_monitor_enable off", 8'h00, {7'h0, tsen});
        fault = CDT_TS_COOL;
        settle();
        chk("hspd ts off", 8'h00, {7'h0, hspd});
        rdc(8'h07, {5'h10, CDT_TS_COOL, 1'b0}, 1'b1);
        fault = CDT_TS_NONE;
        wrc(8'h07, 8'h18);
        ilim = 1'b1;
        settle();
        chk("hspd off", 8'h00, {7'h0, hspd});
        ilim = 1'b0;
        $display("test slowdown done");
    endtask
    task automatic t_unmapped();
        wrc(8'h06, 8'h2a);
        HOST.xfer(1'b1, 8'h08, 8'hff, q, h);
        chk("hit", 8'h00, {7'h0, h});
        rdc(8'h08, 8'h00, 1'b0);
        rdc(8'h06, 8'h2a, 1'b1);
        rdc(8'h07, 8'h18, 1'b1);
        $display("test unmapped done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock_i);
        #1;
        nrst_i = 1'b1;
        t_reset();
        t_thr();
        t_limit();
        t_status();
        t_slow();
        t_unmapped();
        complete_run();
    end
endmodule
`default_nettype wire
